// ### core/sst_top.sv
// Self-test, loopback and word-format logic of one serializer channel
`timescale 1ns/100ps
`default_nettype none
`include "sst_consts.svh"

// ----------------------------------------
// Transmit elastic buffer
// ----------------------------------------
module sst_fifo #(
  parameter int W = 10,
  parameter int D = `SST_FIFO_DEPTH
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         full;

  assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem[rd_q[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (in_valid && in_ready) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_q <= wr_q + {{AW{1'b0}}, 1'b1};
      end
      if (out_valid && out_ready) begin
        rd_q <= rd_q + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // sst_fifo

// ----------------------------------------
// Channel top
// ----------------------------------------
module sst_top import sst_pkg::*; #(
  parameter logic [2:0] CHIP_ID = 3'h0,
  parameter logic [1:0] CHAN_ID = 2'h0,
  parameter int         FIFO_D  = `SST_FIFO_DEPTH
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  input  wire logic       datapath_mode_select,
  input  wire logic       tx_byte_clock,
  input  wire logic [9:0] tx_parallel_word,
  output logic            tx_fifo_ready,
  output logic            serial_tx_pair_p,
  output logic            serial_tx_pair_n,
  input  wire logic       serial_rx_pair,
  input  wire logic       rx_signal_loss,
  output logic            signal_loss_flag,
  output logic [9:0]      rx_parallel_word,
  output logic            rx_byte_clock,
  output logic            rx_word_valid
);
  // 6b and 4b code groups for negative running disparity
  localparam logic [5:0] ENC6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] ENC4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  function automatic logic [10:0] sst_enc(input logic [7:0] b, input logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic       r;
    c6 = ENC6[b[4:0]];
    r  = rd;
    if (r && (($countones(c6) != 3) || (b[4:0] == 5'h07))) begin
      c6 = ~c6;
    end
    r  = r ^ ($countones(c6) != 3);
    c4 = ENC4[b[7:5]];
    if (r && (($countones(c4) != 2) || (b[7:5] == 3'h3))) begin
      c4 = ~c4;
    end
    r  = r ^ ($countones(c4) != 2);
    return {r, c6, c4};
  endfunction

  // Complement forms are only legal where the encoder can produce them
  function automatic logic [8:0] sst_dec(input logic [9:0] w);
    logic [4:0] lo;
    logic [2:0] hi;
    logic       f6;
    logic       f4;
    lo = 5'h00;
    hi = 3'h0;
    f6 = 1'b0;
    f4 = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if ((w[9:4] == ENC6[i]) || ((w[9:4] == ~ENC6[i]) &&
          (($countones(ENC6[i]) != 3) || (i == 7)))) begin
        lo = 5'(i);
        f6 = 1'b1;
      end
    end
    for (int j = 0; j < 8; j++) begin
      if ((w[3:0] == ENC4[j]) || ((w[3:0] == ~ENC4[j]) &&
          (($countones(ENC4[j]) != 2) || (j == 3)))) begin
        hi = 3'(j);
        f4 = 1'b1;
      end
    end
    return {!(f6 && f4), hi, lo};
  endfunction

  // Ten steps of x^7+x^6+1, first generated bit in the MSB
  function automatic logic [16:0] sst_prbs(input logic [6:0] s);
    logic [6:0] l;
    logic [9:0] w;
    l = s;
    w = 10'h000;
    for (int i = 9; i >= 0; i--) begin
      l    = {l[5:0], l[6] ^ l[5]};
      w[i] = l[0];
    end
    return {l, w};
  endfunction

  // ----------------------------------------
  // Input synchronisers and edges
  // ----------------------------------------
  logic [15:0] meta_q;
  logic [15:0] sync_q;
  logic        mdc_d_q;
  logic        tclk_d_q;
  logic        mdc_s;
  logic        mdio_s;
  logic        codec_s;
  logic        tclk_s;
  logic [9:0]  tdat_s;
  logic        srx_s;
  logic        los_s;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_q   <= 16'h0000;
      sync_q   <= 16'h0000;
      mdc_d_q  <= 1'b0;
      tclk_d_q <= 1'b0;
    end else begin
      meta_q   <= {mdc, mdio_in, datapath_mode_select, tx_byte_clock, tx_parallel_word,
                   serial_rx_pair, rx_signal_loss};
      sync_q   <= meta_q;
      mdc_d_q  <= mdc_s;
      tclk_d_q <= tclk_s;
    end
  end

  assign mdc_s   = sync_q[15];
  assign mdio_s  = sync_q[14];
  assign codec_s = sync_q[13];
  assign tclk_s  = sync_q[12];
  assign tdat_s  = sync_q[11:2];
  assign srx_s   = sync_q[1];
  assign los_s   = sync_q[0];
  assign signal_loss_flag = los_s;

  // ----------------------------------------
  // Management frame slave
  // ----------------------------------------
  sst_mdio_st_t st_q;
  logic [5:0]   ones_q;
  logic [13:0]  hdr_q;
  logic [13:0]  hdr_d;
  logic [4:0]   cnt_q;
  logic [15:0]  sh_q;
  logic         rd_q;
  logic         mdio_out_q;
  logic         mdio_oe_q;
  logic [15:0]  rd_data;
  logic         wr_stb;
  logic [15:0]  wr_data;
  logic         mdc_rise;

  assign mdc_rise = mdc_s & ~mdc_d_q;
  assign hdr_d    = {hdr_q[12:0], mdio_s};
  assign wr_stb   = mdc_rise && (st_q == SST_DAT) && (cnt_q == 5'h0F) && !rd_q;
  assign wr_data  = {sh_q[14:0], mdio_s};
  assign mdio_out = mdio_out_q;
  assign mdio_oe  = mdio_oe_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q       <= SST_PRE;
      ones_q     <= 6'h00;
      hdr_q      <= 14'h0000;
      cnt_q      <= 5'h00;
      sh_q       <= 16'h0000;
      rd_q       <= 1'b0;
      mdio_out_q <= 1'b0;
      mdio_oe_q  <= 1'b0;
    end else if (mdc_rise) begin
      case (st_q)
        SST_PRE: begin
          if (mdio_s) begin
            ones_q <= (ones_q == `SST_PRE_ONES) ? ones_q : ones_q + 6'h01;
          end else begin
            ones_q <= 6'h00;
            if (ones_q == `SST_PRE_ONES) begin
              st_q  <= SST_HDR;
              hdr_q <= hdr_d;
              cnt_q <= 5'h01;
            end
          end
        end
        SST_HDR: begin
          hdr_q <= hdr_d;
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'h0D) begin
            cnt_q <= 5'h00;
            rd_q  <= (hdr_d[11:10] == `SST_OP_READ);
            // Other channels' frames are left alone
            if ((hdr_d[13:12] == `SST_ST_CODE) && (hdr_d[9:5] == {CHIP_ID, CHAN_ID}) &&
                ((hdr_d[11:10] == `SST_OP_READ) || (hdr_d[11:10] == `SST_OP_WRITE))) begin
              st_q <= SST_TA;
            end else begin
              st_q <= SST_PRE;
            end
          end
        end
        SST_TA: begin
          if (cnt_q == 5'h00) begin
            cnt_q      <= 5'h01;
            mdio_oe_q  <= rd_q;
            mdio_out_q <= 1'b0;
          end else begin
            st_q       <= SST_DAT;
            cnt_q      <= 5'h00;
            sh_q       <= rd_data;
            mdio_out_q <= rd_q & rd_data[15];
          end
        end
        SST_DAT: begin
          cnt_q      <= cnt_q + 5'h01;
          sh_q       <= {sh_q[14:0], mdio_s};
          mdio_out_q <= rd_q & sh_q[14];
          if (cnt_q == 5'h0F) begin
            st_q       <= SST_PRE;
            mdio_oe_q  <= 1'b0;
            mdio_out_q <= 1'b0;
          end
        end
        default: begin
          st_q      <= SST_PRE;
          mdio_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] rate_q;
  logic [15:0] chan_q;
  logic [15:0] pat_q;
  logic [15:0] stat;
  logic        chk_done_q;
  logic        chk_fail_q;
  logic        chk_en;
  logic        prbs_en;
  logic        user_en;
  logic        inv;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rate_q <= `SST_RATE_RST;
      chan_q <= `SST_CHAN_RST;
      pat_q  <= `SST_PAT_RST; // loopback off after reset
    end else if (wr_stb) begin
      case (hdr_q[4:0])
        `SST_REG_RATE: rate_q <= wr_data;
        `SST_REG_CHAN: chan_q <= wr_data;
        `SST_REG_PAT:  pat_q  <= wr_data;
        default:       rate_q <= rate_q;
      endcase
    end
  end

  assign chk_en  = pat_q[`SST_PAT_CHK_EN];
  assign prbs_en = pat_q[`SST_PAT_PRBS_EN];
  assign user_en = pat_q[`SST_PAT_USER_EN];
  assign inv     = pat_q[`SST_PAT_INV];

  always_comb begin
    stat = 16'h0000;
    stat[`SST_STAT_DONE] = chk_en & chk_done_q;
    stat[`SST_STAT_FAIL] = chk_en & chk_fail_q;
  end

  always_comb begin
    case (hdr_q[4:0])
      `SST_REG_RATE: rd_data = rate_q;
      `SST_REG_CHAN: rd_data = chan_q;
      `SST_REG_PAT:  rd_data = pat_q;
      `SST_REG_STAT: rd_data = stat;
      default:       rd_data = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // Transmit path
  // ----------------------------------------
  logic       push;
  logic       fifo_out_valid;
  logic [9:0] fifo_out_data;
  logic       pop;
  logic       div_q;
  logic       tx_bit_en;
  logic       rx_bit_en;
  logic       word_ld;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_cnt_q;
  logic       tx_rd_q;
  logic [6:0] prbs_q;
  logic       alt_q;
  logic [16:0] prbs_nx;
  logic [10:0] enc;
  logic [9:0] next_word;

  // Full rate takes words on both byte clock edges, half rate on rising only
  assign push = (tclk_s & ~tclk_d_q) | (rate_q[`SST_RATE_TXFULL] & ~tclk_s & tclk_d_q);

  // Elastic buffer absorbs byte clock phase; latency depends on fill at reset
  sst_fifo #(.W(10), .D(FIFO_D)) u_txfifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (tx_fifo_ready),
    .in_data   (tdat_s),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_q <= 1'b0;
    end else begin
      div_q <= ~div_q;
    end
  end

  assign tx_bit_en = chan_q[`SST_CHAN_EN] & (rate_q[`SST_RATE_TXFULL] | div_q);
  assign rx_bit_en = chan_q[`SST_CHAN_EN] & (rate_q[`SST_RATE_RXFULL] | div_q);
  assign word_ld   = tx_bit_en && (tx_cnt_q == 4'h9);
  // Test sources hold the buffer; the source sees back-pressure until they stop
  assign pop       = word_ld & ~prbs_en & ~user_en;
  assign prbs_nx   = sst_prbs(prbs_q);
  assign enc       = sst_enc(fifo_out_valid ? fifo_out_data[7:0] : 8'h00, tx_rd_q);

  always_comb begin
    if (prbs_en) begin
      next_word = prbs_nx[9:0] ^ {10{inv}};
    end else if (user_en) begin
      next_word = (inv & alt_q) ? ~pat_q[9:0] : pat_q[9:0];
    end else if (codec_s) begin
      next_word = enc[9:0];
    end else begin
      next_word = fifo_out_valid ? fifo_out_data : 10'h000;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prbs_q <= `SST_SEED_FIX;
      alt_q  <= 1'b0;
    end else begin
      // Seed reloads whenever the generator is off; a zero state would lock up
      if (!prbs_en) begin
        prbs_q <= (pat_q[6:0] == 7'h00) ? `SST_SEED_FIX : pat_q[6:0];
      end else if (word_ld) begin
        prbs_q <= prbs_nx[16:10];
      end
      if (!user_en || prbs_en) begin
        alt_q <= 1'b0;
      end else if (word_ld) begin
        alt_q <= ~alt_q;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || !chan_q[`SST_CHAN_EN]) begin
      tx_sh_q  <= 10'h000;
      tx_cnt_q <= 4'h9;
      tx_rd_q  <= 1'b0;
    end else if (tx_bit_en) begin
      if (word_ld) begin
        tx_sh_q  <= next_word;
        tx_cnt_q <= 4'h0;
        if (!prbs_en && !user_en && codec_s) begin
          tx_rd_q <= enc[10];
        end
      end else begin
        tx_sh_q  <= {tx_sh_q[8:0], 1'b0};
        tx_cnt_q <= tx_cnt_q + 4'h1;
      end
    end
  end

  assign serial_tx_pair_p = tx_sh_q[9];
  assign serial_tx_pair_n = ~tx_sh_q[9];

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  logic       rx_bit;
  logic [9:0] rx_sh_q;
  logic [9:0] rx_win;
  logic [3:0] rx_cnt_q;
  logic       comma;
  logic       rx_end;
  logic [8:0] dec;
  logic [9:0] rx_word_q;
  logic       rx_clk_q;
  logic       rx_vld_q;

  assign rx_bit = pat_q[`SST_PAT_LOOP] ? tx_sh_q[9] : srx_s;
  assign rx_win = {rx_sh_q[8:0], rx_bit};
  assign comma  = chan_q[`SST_CHAN_ALIGN] &&
                  ((rx_win[9:3] == `SST_COMMA_POS) || (rx_win[9:3] == `SST_COMMA_NEG));
  assign rx_end = rx_bit_en && ((rx_cnt_q == 4'h9) || comma);
  assign dec    = sst_dec(rx_win);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_sh_q   <= 10'h000;
      rx_cnt_q  <= 4'h0;
      rx_word_q <= 10'h000;
      rx_clk_q  <= 1'b0;
      rx_vld_q  <= 1'b0;
    end else begin
      rx_vld_q <= rx_end;
      if (rx_bit_en) begin
        rx_sh_q  <= rx_win;
        rx_cnt_q <= rx_end ? 4'h0 : rx_cnt_q + 4'h1;
      end
      if (rx_end) begin
        rx_clk_q <= ~rx_clk_q;
        if (codec_s) begin
          // Pin loss still shows in loopback, whatever the receive pair carries
          rx_word_q <= {los_s | dec[8], 1'b0, dec[7:0]};
        end else begin
          rx_word_q <= rx_win;
        end
      end
    end
  end

  assign rx_parallel_word = rx_word_q;
  assign rx_byte_clock    = rx_clk_q;
  assign rx_word_valid    = rx_vld_q;

  // ----------------------------------------
  // Pattern checker
  // ----------------------------------------
  logic [6:0] hist_q;
  logic [2:0] fill_q;
  logic [9:0] chk_cnt_q;
  logic [6:0] hist_d;
  logic [2:0] fill_d;
  logic       prbs_err;
  logic       miss;

  // Self-synchronising: the first seven bits only seed the history
  always_comb begin
    hist_d   = hist_q;
    fill_d   = fill_q;
    prbs_err = 1'b0;
    for (int i = 9; i >= 0; i--) begin
      if ((fill_d == 3'h7) && (rx_win[i] != (hist_d[6] ^ hist_d[5] ^ inv))) begin
        prbs_err = 1'b1;
      end
      hist_d = {hist_d[5:0], rx_win[i]};
      fill_d = (fill_d == 3'h7) ? fill_d : fill_d + 3'h1;
    end
  end

  always_comb begin
    if (prbs_en) begin
      miss = prbs_err;
    end else if (user_en) begin
      miss = !((rx_win == pat_q[9:0]) || (inv && (rx_win == ~pat_q[9:0])));
    end else begin
      miss = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || !chk_en) begin
      hist_q     <= 7'h00;
      fill_q     <= 3'h0;
      chk_cnt_q  <= 10'h000;
      chk_done_q <= 1'b0;
      chk_fail_q <= 1'b0;
    end else if (rx_end && !chk_done_q) begin
      hist_q     <= hist_d;
      fill_q     <= fill_d;
      chk_cnt_q  <= chk_cnt_q + 10'h001;
      chk_fail_q <= chk_fail_q | miss;
      if (chk_cnt_q == `SST_CHECK_LAST) begin
        chk_done_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_STAT_CLEAR: assert property ($fell(chk_en) |=> !chk_done_q && !chk_fail_q && stat == 16'h0000)
    else $error("status not cleared when checking disabled");
  AST_DONE_COUNT: assert property ($rose(chk_done_q) |-> $past(chk_cnt_q) == 10'h1FF)
    else $error("test complete before 512 words");
  AST_FAIL_HOLD: assert property (chk_fail_q && chk_en |=> chk_fail_q)
    else $error("failure flag dropped while checking");
  AST_CHK_COUNT: assert property (rx_end && chk_en && !chk_done_q |=>
    chk_cnt_q == 10'($past(chk_cnt_q) + 10'h001))
    else $error("checker did not count a received word");
  AST_PRBS_SEND: assert property (word_ld && prbs_en |=>
    tx_sh_q == ($past(prbs_nx[9:0]) ^ {10{$past(inv)}}))
    else $error("prbs word not sent");
  AST_USER_SEND: assert property (word_ld && user_en && !prbs_en && !inv |=> tx_sh_q == $past(pat_q[9:0]))
    else $error("user word not sent");
  AST_USER_ALT: assert property (word_ld && user_en && !prbs_en && inv && alt_q |=>
    tx_sh_q == ~$past(pat_q[9:0]))
    else $error("inverse user word not sent");
  AST_MSB_FIRST: assert property (tx_bit_en && (tx_cnt_q != 4'h9) |=> tx_sh_q[9] == $past(tx_sh_q[8]))
    else $error("serial order broken");
  // A switch to full rate may legally give two bits in a row
  AST_HALF_RATE: assert property (!rate_q[`SST_RATE_TXFULL] && tx_bit_en |=>
    !(tx_bit_en && !rate_q[`SST_RATE_TXFULL]))
    else $error("half rate sent two bits in a row");
  AST_LOOP_BIT: assert property (pat_q[`SST_PAT_LOOP] && rx_bit_en |=> rx_sh_q[0] == $past(tx_sh_q[9]))
    else $error("loopback bit mismatch");
  AST_CODEC_LOS: assert property (rx_end && codec_s && los_s |=> rx_parallel_word[9] && rx_word_valid)
    else $error("signal loss not flagged in codec word");
  AST_RXCLK: assert property (rx_end |=> rx_byte_clock != $past(rx_byte_clock))
    else $error("receive byte clock missed a word");
endmodule // sst_top
`default_nettype wire

// ### core/sst_consts.svh
// Register map, field positions, reset values and counts of the self-test channel
`ifndef SST_CONSTS_SVH
`define SST_CONSTS_SVH
`define SST_REG_RATE     5'h11
`define SST_REG_CHAN     5'h18
`define SST_REG_PAT      5'h19
`define SST_REG_STAT     5'h1B
`define SST_RATE_RST     16'h2000
`define SST_CHAN_RST     16'h0003
`define SST_PAT_RST      16'h0000
`define SST_RATE_TXFULL  0
`define SST_RATE_RXFULL  1
`define SST_RATE_EDGE    13
`define SST_CHAN_EN      0
`define SST_CHAN_ALIGN   1
`define SST_PAT_USER_EN  10
`define SST_PAT_INV      11
`define SST_PAT_PRBS_EN  12
`define SST_PAT_LOOP     13
`define SST_PAT_CHK_EN   14
`define SST_STAT_DONE    11
`define SST_STAT_FAIL    12
`define SST_PRE_ONES     6'h20
`define SST_OP_WRITE     2'h1
`define SST_OP_READ      2'h2
`define SST_ST_CODE      2'h1
`define SST_CHECK_LAST   10'h1FF
`define SST_FIFO_DEPTH   8
`define SST_SEED_FIX     7'h01
`define SST_COMMA_POS    7'h1F
`define SST_COMMA_NEG    7'h60
`endif

// ### core/sst_pkg.sv
// Types shared by the self-test channel
`default_nettype none
package sst_pkg;
  typedef enum logic [1:0] {
    SST_PRE = 2'h0,
    SST_HDR = 2'h1,
    SST_TA  = 2'h3,
    SST_DAT = 2'h2
  } sst_mdio_st_t;
endpackage
`default_nettype wire

// ### bench/sst_partner.sv
// Protocol controller model on the parallel side of one channel
`timescale 1ns/100ps
`default_nettype none
module sst_partner (
  input  wire logic       tx_fifo_ready,
  output logic            tx_byte_clock,
  output logic [9:0]      tx_parallel_word
);
  int seed = 47819;
  // Byte clock runs free; words move mid-period so both edges see them settled
  // A full buffer stalls the controller, which then holds its word
  initial begin
    tx_byte_clock = 1'b0;
    tx_parallel_word = 10'h000;
    #7.3;
    forever begin
      #31.25;
      if (tx_fifo_ready) begin
        tx_parallel_word = 10'($random(seed));
      end
      #31.25 tx_byte_clock = ~tx_byte_clock;
    end
  end
endmodule // sst_partner
`default_nettype wire

// ### bench/sst_top_tb.sv
// Self-checking bench of the self-test channel
`timescale 1ns/100ps
`default_nettype none
`include "sst_consts.svh"
module sst_top_tb;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        mdc = 1'b0;
  logic        mdio_drv = 1'b1;
  logic        mode = 1'b0;
  logic        loss = 1'b0;
  logic        flip = 1'b0;
  logic        mdio_out, mdio_oe, tx_clk, tx_rdy, tx_p, tx_n, rx_valid, loss_flag, rx_clk, clk_seen;
  logic [9:0]  tx_word, rx_word, pat;
  logic [15:0] rd;
  int          err_total = 0;
  int          check_count = 0;
  int          seed = 47819;
  // Released line follows mdio_drv, which a read frame holds high through turnaround and data
  wire         mdio_w = mdio_oe ? mdio_out : mdio_drv;

  always #2 mclk = ~mclk;

  sst_top i_dut (.mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_w), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .datapath_mode_select(mode), .tx_byte_clock(tx_clk), .tx_parallel_word(tx_word),
    .tx_fifo_ready(tx_rdy), .serial_tx_pair_p(tx_p), .serial_tx_pair_n(tx_n), .serial_rx_pair(tx_p ^ flip),
    .rx_signal_loss(loss), .signal_loss_flag(loss_flag), .rx_parallel_word(rx_word), .rx_byte_clock(rx_clk),
    .rx_word_valid(rx_valid));
  sst_partner i_ctl (.tx_fifo_ready(tx_rdy), .tx_byte_clock(tx_clk), .tx_parallel_word(tx_word));

  // ----------------------------------------
  // Management frames and comparisons
  // ----------------------------------------
  task automatic frame(input logic [4:0] phy, input logic [1:0] op, input logic [4:0] ra,
                       input logic [15:0] wd);
    logic [63:0] f;
    f = {32'hFFFFFFFF, 2'b01, op, phy, ra, (op == `SST_OP_WRITE) ? {2'b10, wd} : {2'b11, 16'hFFFF}};
    for (int i = 63; i >= 0; i--) begin
      mdio_drv <= f[i];
      mdc <= 1'b0;
      repeat (50) @(posedge mclk);
      rd = {rd[14:0], mdio_w};
      mdc <= 1'b1;
      repeat (50) @(posedge mclk);
    end
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rchk(input logic [4:0] ra, input logic [15:0] e, input string n);
    frame(5'h00, `SST_OP_READ, ra, 16'h0000);
    chk(n, e, rd);
  endtask

  function automatic logic [15:0] stat_exp(input logic done, input logic fail);
    return (16'(done) << `SST_STAT_DONE) | (16'(fail) << `SST_STAT_FAIL);
  endfunction

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rchk(`SST_REG_RATE, `SST_RATE_RST, "rate");
    rchk(`SST_REG_CHAN, `SST_CHAN_RST, "chan");
    rchk(5'h05, 16'h0000, "unmapped");
    frame(5'h00, `SST_OP_WRITE, `SST_REG_STAT, 16'hFFFF);
    frame(5'h01, `SST_OP_WRITE, `SST_REG_PAT, 16'h7FFF);
    rchk(`SST_REG_PAT, `SST_PAT_RST, "pattern");
    frame(5'h00, `SST_OP_WRITE, `SST_REG_RATE, 16'h0003);
    frame(5'h00, `SST_OP_WRITE, `SST_REG_CHAN, 16'h0001);
    pat = 10'({$random(seed)} % 1022 + 1);
    frame(5'h00, `SST_OP_WRITE, `SST_REG_PAT, {6'h00, pat} | 16'h3C00);
    frame(5'h00, `SST_OP_WRITE, `SST_REG_PAT, {6'h00, pat} | 16'h7C00);
    // 512 words take 5120 cycles; the status read latches about 4750 cycles into its frame
    repeat (1000) @(posedge mclk);
    chk("fifo ready", 16'h0000, 16'(tx_rdy));
    rchk(`SST_REG_STAT, stat_exp(1'b1, 1'b0), "prbs status");
    flip <= 1'b1;
    pat = 10'({$random(seed)} % 1022 + 1);
    frame(5'h00, `SST_OP_WRITE, `SST_REG_PAT, {6'h00, pat} | 16'h0400);
    rchk(`SST_REG_STAT, 16'h0000, "idle status");
    frame(5'h00, `SST_OP_WRITE, `SST_REG_PAT, {6'h00, pat} | 16'h4400);
    repeat (1000) @(posedge mclk);
    rchk(`SST_REG_STAT, stat_exp(1'b1, 1'b1), "user status");
    mode <= 1'b1;
    loss <= 1'b1;
    repeat (200) @(posedge mclk);
    chk("loss flag", 16'h0001, 16'(loss_flag));
    repeat (100) begin
      @(negedge mclk);
      if (rx_valid === 1'b1) break;
    end
    chk("codec word", 16'h0002, 16'(rx_word[9:8]));
    clk_seen = rx_clk;
    // Full receive rate gives one word, and one byte clock edge, per ten cycles
    repeat (10) @(negedge mclk);
    chk("rx byte clock", {15'h0000, ~clk_seen}, {15'h0000, rx_clk});
    chk("tx pair", 16'h0001, {15'h0000, tx_p ^ tx_n});
    summarize();
  end

  // Fifteen frames of 6400 cycles and about 2300 cycles of waits fit below this
  initial begin
    repeat (100000) @(posedge mclk);
    err_total++;
    summarize();
  end
endmodule // sst_top_tb
`default_nettype wire
